// ---- bench/i2c_slave_address_decode_clocking_tb_top.sv ----
/* testbench top: apb master, bus model, read notes queue and scenarios.
   assumes isa_core on a 10 MHz clock with pulled-up open-drain lines. */
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_address_decode_clocking_tb_top;
  import isa_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m; logic err;} isa_exp_t;
  // ****************************************
  // signals, clock and instances
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hw_rst = 1'b0, ext = 1'b0;
  logic oe_bad = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, wake, irq, scl_m, sda_m, ack;
  logic [6:0] own;
  wire logic scl_free, scl_line, sda_line;
  isa_exp_t exp_q[$];
  isa_exp_t x;
  int n_fail = 0, tests_run = 0, cyc = 0, wake_cnt = 0, seed = 29;
  always #50 pclk = ~pclk; // steady 10 MHz
  // wired-and of pull-up, controller model and block drivers
  assign scl_free = ext ? scl_o : !scl_oe;
  assign scl_line = scl_m & scl_free;
  assign sda_line = sda_m & (ext ? sda_o : !sda_oe);
  isa_i2c_master mdl (.pclk(pclk), .scl_line(scl_line), .sda_line(sda_line), .scl_m(scl_m),
    .sda_m(sda_m));
  isa_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_rst(hw_rst), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .wake(wake), .irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one apb transfer; for a read, d is noted as the expected word
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m = 32'hffffffff, input logic err = 1'b0);
    if (!w) exp_q.push_back('{d, m, err});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // address byte, answer check, stretch check, software release, stop
  task automatic xfer(input logic [7:0] b, input logic want_nak, input logic held);
    mdl.start_cond();
    mdl.send_addr(b, ack);
    chk({31'h0, ack}, {31'h0, want_nak});
    repeat (40) @(posedge pclk);
    chk({31'h0, !scl_free}, {31'h0, held});
    if (held) apb(1'b1, OFF_CMD, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, scl_free}, 32'h1);
    mdl.stop_cond();
  endtask
  // read answers against the oldest note, wake count, drivers in ext mode, ceiling
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (ext && (scl_oe !== 1'b0 || sda_oe !== 1'b0)) oe_bad <= 1'b1;
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) n_fail++;
      x = exp_q.pop_front();
      chk(prdata & x.m, x.e & x.m);
      chk({31'h0, pslverr}, {31'h0, x.err});
    end
    if (cyc == 30000) begin
      n_fail++;
      end_of_test();
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_CTRL, 32'h12);
    apb(1'b0, OFF_ADDR, 32'h08);
    apb(1'b0, OFF_MASK, 32'h0);
    apb(1'b0, OFF_STAT, 32'h0);
    apb(1'b0, 8'h1c, 32'h0, 32'hffffffff, 1'b1);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, OFF_CTRL, 32'(32'h3 | (r << 4)));
      apb(1'b0, OFF_STATE, 32'(((r == 0) ? 32 : 16) << 14), 32'h000fc000);
    end
    d = $random(seed);
    apb(1'b1, OFF_DIV, d);
    apb(1'b0, OFF_DIV, {24'h0, d[7:0]});
    d = $random(seed);
    own = d[6:0];
    apb(1'b1, OFF_ADDR, d);
    apb(1'b0, OFF_ADDR, {25'h0, own});
    apb(1'b1, OFF_CTRL, 32'h23);
    xfer({own ^ 7'h01, 1'b0}, 1'b1, 1'b0);
    apb(1'b0, OFF_STAT, 32'h6);
    xfer({own, 1'b0}, 1'b0, 1'b1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFF_MASK, 32'h1f);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, OFF_STAT, 32'h5);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    chk(32'(wake_cnt), 32'h0);
    apb(1'b1, OFF_CTRL, 32'h67);
    mdl.half = 40;
    xfer({own, 1'b1}, 1'b0, 1'b1);
    chk(32'(wake_cnt), 32'h1);
    apb(1'b0, OFF_STAT, 32'h15);
    apb(1'b1, OFF_CTRL, 32'h2b);
    ext <= 1'b1;
    mdl.half = 20;
    xfer({own, 1'b0}, 1'b0, 1'b1);
    chk({31'h0, oe_bad}, 32'h0);
    apb(1'b0, OFF_STAT, 32'h5);
    ext <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h21);
    fork
      xfer({own ^ 7'h05, 1'b0}, 1'b0, 1'b0);
      begin
        while (scl_free) @(posedge pclk);
        apb(1'b1, OFF_CMD, 32'h3);
      end
    join
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFF_MASK, 32'h0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, OFF_STAT, 32'hc);
    apb(1'b1, OFF_CTRL, 32'h23);
    // engine reset while the clock is stretched must let the line go
    mdl.start_cond();
    mdl.send_addr({own, 1'b0}, ack);
    chk({31'h0, ack}, 32'h0);
    repeat (40) @(posedge pclk);
    chk({31'h0, !scl_free}, 32'h1);
    hw_rst <= 1'b1;
    repeat (10) @(posedge pclk);
    chk({31'h0, scl_free}, 32'h1);
    hw_rst <= 1'b0;
    mdl.stop_cond();
    apb(1'b0, OFF_STAT, 32'h5);
    hw_rst <= 1'b1;
    xfer({own, 1'b0}, 1'b1, 1'b0);
    hw_rst <= 1'b0;
    apb(1'b0, OFF_ADDR, {25'h0, own});
    end_of_test();
  end
endmodule // i2c_slave_address_decode_clocking_tb_top
bind isa_core isa_core_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .hw_rst(hw_rst), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .wake(wake), .irq(irq));
`default_nettype wire

// ---- bench/isa_core_sva.sv ----
/* checker for isa_core: apb timing, line drive, stretch release, wake pulse.
   assumes it is bound to isa_core and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module isa_core_sva
  import isa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hw_rst,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic wake,
  input wire logic irq
);
  // ****************************************
  // helper counter and properties
  // ****************************************
  logic [3:0] wr_age_reg;
  // cycles since the last apb write or engine reset, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_age_reg <= 4'hf;
    else if ((pready && pwrite) || hw_rst) wr_age_reg <= 4'h0;
    else if (wr_age_reg != 4'hf) wr_age_reg <= wr_age_reg + 4'h1;
  end
  // apb write that clears every mask bit
  wire logic mask_clr = pready && pwrite && paddr == OFF_MASK && pwdata[NSTAT-1:0] == '0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not exactly one cycle after setup");
  bad_addr_a: assert property (pready && paddr > 8'h18 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  idle_data_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error outside access");
  rst_quiet_a: assert property ($rose(presetn) |-> !irq && !wake && !scl_oe && !sda_oe)
    else $error("outputs active right after reset");
  stretch_end_a: assert property ($fell(scl_oe) |-> wr_age_reg < 4'h4)
    else $error("clock released without software");
  ack_low_a: assert property ($rose(sda_oe) |-> !$past(scl_i))
    else $error("ack driven while clock high");
  engine_rst_a: assert property (hw_rst [*5] |-> !scl_oe && !sda_oe)
    else $error("lines driven during engine reset");
  wake_pulse_a: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  drive_low_a: assert property (!(scl_oe && scl_o) && !(sda_oe && sda_o))
    else $error("enabled driver not driving low");
  mask_off_a: assert property (mask_clr |=> ##1 !irq)
    else $error("interrupt stays with mask cleared");
  cover property ($rose(sda_oe));
  cover property ($rose(scl_oe));
  cover property (wake);
  cover property (pready && pslverr);
endmodule // isa_core_sva
`default_nettype wire

// ---- bench/isa_i2c_master.sv ----
/* i2c bus controller model: start, address byte, ack sampling, stop.
   assumes open-drain lines whose pull-up level the bench resolves. */
`timescale 1ns/1ps
`default_nettype none
module isa_i2c_master (
  input wire logic pclk,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_m,
  output logic sda_m
);
  // ****************************************
  // bus phases
  // ****************************************
  int half = 20;
  // both lines released at start
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // release clock, honour any stretch, then keep it high
  task automatic clk_high;
    scl_m <= 1'b1;
    @(posedge pclk);
    while (!scl_line) @(posedge pclk);
    repeat (half) @(posedge pclk);
  endtask
  // pull clock low, give data a short hold
  task automatic clk_low;
    scl_m <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic start_cond;
    sda_m <= 1'b1;
    repeat (half) @(posedge pclk);
    clk_high();
    sda_m <= 1'b0;
    repeat (half) @(posedge pclk);
    clk_low();
  endtask
  // msb first, then release data for the ninth clock
  task automatic send_addr(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      sda_m <= b[i];
      repeat (half) @(posedge pclk);
      clk_high();
      clk_low();
    end
    sda_m <= 1'b1;
    repeat (half) @(posedge pclk);
    clk_high();
    nak = sda_line;
    clk_low();
  endtask
  task automatic stop_cond;
    sda_m <= 1'b0;
    repeat (half) @(posedge pclk);
    clk_high();
    sda_m <= 1'b1;
    repeat (half) @(posedge pclk);
  endtask
endmodule // isa_i2c_master
`default_nettype wire

// ---- src/isa_core.sv ----
/*
 * i2c target front end: own-address decode, ack or refusal, clock
 * stretching until software releases, wake on match, bit clock selection,
 * apb register file with sticky status and one interrupt line.
 * assumes scl/sda/hw_rst arrive asynchronously and an external pull-up.
 */
// The placing of the registers and the APB slave port were left to the implementer.
// Overview of operation
// - hardware decode refuses foreign addresses with nak, no software involved
// - hardware decode raises an interrupt on own address match
// - after a match hold scl low until software releases
// - bit clock is the system clock divided for oversampling
// - 50 kbps uses thirty-two ticks per bus bit
// - other fixed rates use sixteen ticks per bus bit
// - fixed engine offers only 50, 100 and 400 kbps
// - programmable divider path serves other rates up to 1 Mbps
// - multiple or ten-bit addresses need software decode, not hardware
// - wake enabled: own address match wakes system, hw decode, dedicated pins
// - wake on match is off after reset unless selected
// - external enable option: no internal tristate, separate sense and drive
// - own address is seven bits, right-justified, no direction bit
// - high hw reset holds the engine in reset, unconnected reads low
`timescale 1ns/1ps
`default_nettype none
module isa_core
  import isa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_rst,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic wake,
  output logic irq
);

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] ctrl_reg;
  logic [6:0] addr_reg;
  logic [7:0] div_reg;
  logic [NSTAT-1:0] stat_reg;
  logic [NSTAT-1:0] stat_next;
  logic [NSTAT-1:0] mask_reg;
  logic [1:0] scl_sy_reg;
  logic [1:0] sda_sy_reg;
  logic [1:0] rst_sy_reg;
  logic smp_scl_reg;
  logic smp_sda_reg;
  logic prv_scl_reg;
  logic prv_sda_reg;
  logic tick_q_reg;
  logic tick;
  isa_state_t st_reg;
  isa_state_t st_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic ack_reg;
  logic ack_next;
  logic seen_hi_reg;
  logic seen_hi_next;
  logic [NSTAT-1:0] ev;
  logic [31:0] rd_mux;

  // ****************************************
  // apb decode
  // ****************************************
  wire logic setup = psel & ~penable;
  wire logic acc = psel & penable & pready;
  wire logic wr_en = acc & pwrite;
  wire logic rd_en = acc & ~pwrite;
  wire logic hit_ctrl = (paddr == OFF_CTRL);
  wire logic hit_addr = (paddr == OFF_ADDR);
  wire logic hit_stat = (paddr == OFF_STAT);
  wire logic hit_mask = (paddr == OFF_MASK);
  wire logic hit_cmd = (paddr == OFF_CMD);
  wire logic hit_div = (paddr == OFF_DIV);
  wire logic hit_state = (paddr == OFF_STATE);
  wire logic mapped = hit_ctrl | hit_addr | hit_stat | hit_mask | hit_cmd | hit_div
                      | hit_state;
  wire logic release_cmd = wr_en & hit_cmd & pwdata[CMD_RELEASE];
  wire logic ack_cmd = pwdata[CMD_ACK];

  // ****************************************
  // configuration fields
  // ****************************************
  wire logic en = ctrl_reg[CTRL_EN];
  wire logic hw_dec = ctrl_reg[CTRL_HWDEC];
  wire logic wake_en = ctrl_reg[CTRL_WAKE];
  wire logic ext_oe = ctrl_reg[CTRL_EXTOE];
  wire isa_rate_t rate = isa_rate_t'(ctrl_reg[CTRL_RATE_LO +: 2]);
  wire isa_pins_t pins = isa_pins_t'(ctrl_reg[CTRL_PIN_LO +: 2]);

  // ****************************************
  // bit clock selection
  // ****************************************
  // divisor per rate; the custom path uses the software divider
  wire logic [7:0] div_sel = (rate == RATE_50K) ? DIV_50K :
                             (rate == RATE_100K) ? DIV_100K :
                             (rate == RATE_400K) ? DIV_400K :
                             div_reg;
  wire logic [5:0] os_sel = (rate == RATE_50K) ? OS_LOW_W : OS_STD_W;
  wire logic eng_rst = rst_sy_reg[1];
  wire logic run = en & ~eng_rst;

  isa_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .div(div_sel),
    .tick(tick)
  );

  // ****************************************
  // line events on sampled levels
  // ****************************************
  wire logic scl_rise = tick_q_reg & smp_scl_reg & ~prv_scl_reg;
  wire logic scl_fall = tick_q_reg & ~smp_scl_reg & prv_scl_reg;
  wire logic start_c = tick_q_reg & smp_scl_reg & prv_scl_reg & prv_sda_reg & ~smp_sda_reg;
  wire logic stop_c = tick_q_reg & smp_scl_reg & prv_scl_reg & ~prv_sda_reg & smp_sda_reg;
  wire logic match = (sh_reg[7:1] == addr_reg);
  wire logic wake_ok = wake_en & hw_dec & (pins != PINS_ANY);

  // ****************************************
  // address state machine
  // ****************************************
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    ack_next = ack_reg;
    seen_hi_next = seen_hi_reg;
    ev = '0;
    if (!run) begin
      st_next = S_IDLE;
      ack_next = 1'b0;
    end else if (start_c) begin
      st_next = S_ADDR;
      cnt_next = 4'h0;
      ack_next = 1'b0;
    end else if (stop_c) begin
      st_next = S_IDLE;
      ack_next = 1'b0;
      ev[ST_STOP] = 1'b1;
    end else begin
      case (st_reg)
        S_IDLE: begin
          st_next = S_IDLE;
        end
        S_ADDR: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], smp_sda_reg};
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == 4'h7) begin
              st_next = S_DECIDE;
            end
          end
        end
        S_DECIDE: begin
          if (scl_fall) begin
            seen_hi_next = 1'b0;
            if (!hw_dec) begin
              st_next = S_HOLD;
              ev[ST_SWADDR] = 1'b1;
            end else if (match) begin
              st_next = S_ACK;
              ack_next = 1'b1;
              ev[ST_MATCH] = 1'b1;
              ev[ST_WAKE] = wake_ok;
            end else begin
              st_next = S_BUSY;
              ev[ST_FOREIGN] = 1'b1;
            end
          end
        end
        S_HOLD: begin
          if (release_cmd) begin
            st_next = S_ACK;
            ack_next = ack_cmd;
          end
        end
        S_ACK: begin
          if (scl_rise) begin
            seen_hi_next = 1'b1;
          end
          if (scl_fall && seen_hi_reg) begin
            ack_next = 1'b0;
            st_next = (hw_dec && ack_reg) ? S_STRETCH : S_BUSY;
          end
        end
        S_STRETCH: begin
          if (release_cmd) begin
            st_next = S_BUSY;
          end
        end
        S_BUSY: begin
          st_next = S_BUSY;
        end
        default: begin
          st_next = S_IDLE;
        end
      endcase
    end
  end

  // line drive demands from the state
  wire logic scl_low = (st_reg == S_HOLD) | (st_reg == S_STRETCH);
  wire logic sda_low = ack_reg;

  // ****************************************
  // status, interrupt and read mux
  // ****************************************
  // a read clears only the bits it returned; a new event wins over the clear
  wire logic [NSTAT-1:0] rd_clr = (rd_en & hit_stat) ? prdata[NSTAT-1:0] : '0;
  assign stat_next = (stat_reg & ~rd_clr) | ev;
  wire logic irq_next = |(stat_next & mask_reg);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      hit_ctrl: rd_mux = {24'h00_0000, ctrl_reg};
      hit_addr: rd_mux = {25'h000_0000, addr_reg};
      hit_stat: rd_mux = {27'h000_0000, stat_reg};
      hit_mask: rd_mux = {27'h000_0000, mask_reg};
      hit_div: rd_mux = {24'h00_0000, div_reg};
      hit_state: rd_mux = {12'h000, os_sel, eng_rst, scl_low, st_reg, 1'b0, sh_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy_reg <= 2'b11;
      sda_sy_reg <= 2'b11;
      rst_sy_reg <= 2'b00;
    end else begin
      scl_sy_reg <= {scl_sy_reg[0], scl_i};
      sda_sy_reg <= {sda_sy_reg[0], sda_i};
      rst_sy_reg <= {rst_sy_reg[0], hw_rst};
    end
  end

  // sample the synchronised lines once per bit-clock tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_scl_reg <= 1'b1;
      smp_sda_reg <= 1'b1;
      prv_scl_reg <= 1'b1;
      prv_sda_reg <= 1'b1;
      tick_q_reg <= 1'b0;
    end else begin
      tick_q_reg <= tick;
      if (tick) begin
        smp_scl_reg <= scl_sy_reg[1];
        smp_sda_reg <= sda_sy_reg[1];
        prv_scl_reg <= smp_scl_reg;
        prv_sda_reg <= smp_sda_reg;
      end
    end
  end

  // ****************************************
  // engine registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= S_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
      seen_hi_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      ack_reg <= ack_next;
      seen_hi_reg <= seen_hi_next;
    end
  end

  // pin drivers: internal open drain, or split sense/drive levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_o <= 1'b1;
      scl_oe <= 1'b0;
      sda_o <= 1'b1;
      sda_oe <= 1'b0;
    end else begin
      scl_o <= ext_oe ? ~scl_low : 1'b0;
      scl_oe <= ext_oe ? 1'b0 : scl_low;
      sda_o <= ext_oe ? ~sda_low : 1'b0;
      sda_oe <= ext_oe ? 1'b0 : sda_low;
    end
  end

  // ****************************************
  // apb registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      addr_reg <= ADDR_RST;
      div_reg <= DIV_RST;
      mask_reg <= '0;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_reg <= pwdata[7:0];
      if (hit_addr) addr_reg <= pwdata[6:0];
      if (hit_div) div_reg <= pwdata[7:0];
      if (hit_mask) mask_reg <= pwdata[NSTAT-1:0];
    end
  end

  // bus answer: zero wait states, error on unmapped offsets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // sticky status, interrupt level and wake pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= '0;
      irq <= 1'b0;
      wake <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq <= irq_next;
      wake <= ev[ST_WAKE];
    end
  end

endmodule // isa_core
`default_nettype wire

// ---- src/isa_pkg.sv ----
/*
 * shared constants for the slave address decode and bus clocking block:
 * register offsets, field positions, reset values, divider counts and states.
 * assumes a 10 MHz apb clock and a 32-bit apb data path.
 */
package isa_pkg;

  // ****************************************
  // clock and rates
  // ****************************************
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned RATE_50K_BPS = 50000;
  localparam int unsigned RATE_100K_BPS = 100000;
  localparam int unsigned RATE_400K_BPS = 400000;
  localparam int unsigned OS_LOW = 32;
  localparam int unsigned OS_STD = 16;
  // bit clock dividers: longest tick period rounds down, never below one cycle
  localparam int unsigned D50 = CLK_HZ / (RATE_50K_BPS * OS_LOW);
  localparam int unsigned D100 = CLK_HZ / (RATE_100K_BPS * OS_STD);
  localparam int unsigned D400 = CLK_HZ / (RATE_400K_BPS * OS_STD);
  localparam logic [7:0] DIV_50K = 8'((D50 < 1) ? 1 : D50);
  localparam logic [7:0] DIV_100K = 8'((D100 < 1) ? 1 : D100);
  localparam logic [7:0] DIV_400K = 8'((D400 < 1) ? 1 : D400);
  localparam logic [5:0] OS_LOW_W = 6'(OS_LOW);
  localparam logic [5:0] OS_STD_W = 6'(OS_STD);

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_DIV = 8'h14;
  localparam logic [7:0] OFF_STATE = 8'h18;

  // control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_HWDEC = 1;
  localparam int CTRL_WAKE = 2;
  localparam int CTRL_EXTOE = 3;
  localparam int CTRL_RATE_LO = 4;
  localparam int CTRL_PIN_LO = 6;
  localparam logic [7:0] CTRL_RST = 8'h12;
  localparam logic [6:0] ADDR_RST = 7'h08;
  localparam logic [7:0] DIV_RST = 8'h01;

  // status / mask bits
  localparam int ST_MATCH = 0;
  localparam int ST_FOREIGN = 1;
  localparam int ST_STOP = 2;
  localparam int ST_SWADDR = 3;
  localparam int ST_WAKE = 4;
  localparam int NSTAT = 5;

  // command bits
  localparam int CMD_RELEASE = 0;
  localparam int CMD_ACK = 1;

  typedef enum logic [1:0] {
    RATE_50K = 2'b00,
    RATE_100K = 2'b01,
    RATE_400K = 2'b10,
    RATE_CUSTOM = 2'b11
  } isa_rate_t;

  typedef enum logic [1:0] {
    PINS_ANY = 2'b00,
    PINS_PAIR_A = 2'b01,
    PINS_PAIR_B = 2'b10
  } isa_pins_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_DECIDE = 3'b010,
    S_HOLD = 3'b011,
    S_ACK = 3'b100,
    S_STRETCH = 3'b101,
    S_BUSY = 3'b110
  } isa_state_t;

endpackage

// ---- src/isa_tick_gen.sv ----
/*
 * bit clock divider: one-cycle tick every div cycles of pclk.
 * assumes div is static while run is high; div of zero acts as one.
 */
`timescale 1ns/1ps
`default_nettype none
module isa_tick_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [7:0] div,
  output logic tick
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic tick_next;
  wire logic wrap = (cnt_reg + 8'h01 >= div);

  // count up to the divisor, then wrap and tick
  assign cnt_next = (!run || wrap) ? 8'h00 : cnt_reg + 8'h01;
  assign tick_next = run & wrap;

  // ****************************************
  // divider registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick <= tick_next;
    end
  end
endmodule // isa_tick_gen
`default_nettype wire
